// File: ccfg_regs.sv
`timescale 1ns/1ps
// Behaviour
// [RULE1] Config upper ten bits hold signed phase delay
// [RULE2] DC-block off bit bypasses filter, else global
// [RULE3] Two-bit input select: normal, shorted, +DC, -DC
// [RULE4] Offset high word holds offset bits 23:8
// [RULE5] Offset low upper byte; low byte reads zero
// [RULE6] Gain high word holds unsigned gain bits 23:8
// [RULE7] Gain high resets to 8000h, low to zero
// [RULE8] Gain low upper byte; low byte read-only
// [RULE9] Read-only checksum over map, resets zero
// [RULE10] Host writes only zero to tail word
// [RULE11] Checksum recomputed after every accepted write
`include "ccfg_defs.svh"

module ccfg_regs
	import ccfg_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int ADDR_W = 6
)
(
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                resetn,
	// Register port from the serial front end
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic [DATA_W-1:0]   reg_wdata,
	output logic      [DATA_W-1:0]   reg_rdata,
	output logic                     reg_rvalid,
	// Channel controls to the datapath
	output logic signed [9:0]        channel_phase_delay,
	output logic                     channel_dc_block_off,
	output logic                     channel_dc_block_en,
	input  wire logic [3:0]          global_dc_block_corner,
	output logic      [3:0]          channel_dc_block_corner,
	output ccfg_input_t              channel_input_select,
	output logic      [23:0]         channel_offset,
	output logic      [23:0]         channel_gain,
	// Checksum status
	output logic                     checksum_busy
);

	// Elaboration checks; decode and checksum walk assume these widths
	if (DATA_W != 16)
	begin : g_bad_data_w
		$error("ccfg_regs: DATA_W must be 16");
	end
	if (ADDR_W != 6)
	begin : g_bad_addr_w
		$error("ccfg_regs: ADDR_W must be 6");
	end

	logic [15:0]    channel_config;
	logic [15:0]    channel_offset_hi;
	logic [15:0]    channel_offset_lo;
	logic [15:0]    channel_gain_hi;
	logic [15:0]    channel_gain_lo;
	logic [15:0]    register_map_checksum;
	logic [15:0]    reserved_tail_word;
	ccfg_ck_state_t ck_state;
	logic [2:0]     ck_index;
	logic [15:0]    ck_acc;
	logic           ck_restart;

	// Address decode, shared by write and read paths
	function automatic logic is_addr(input logic [5:0] a, input logic [5:0] ref_a);
		is_addr = (a == ref_a);
	endfunction

	// One CRC step over a whole 16-bit word
	function automatic logic [15:0] crc_word(input logic [15:0] crc, input logic [15:0] d);
		logic [15:0] c;
		c = crc;
		for (int i = 15; i >= 0; i--)
		begin
			if (c[15] ^ d[i])
				c = {c[14:0], 1'b0} ^ `CCFG_CRC_POLY;
			else
				c = {c[14:0], 1'b0};
		end
		crc_word = c;
	endfunction

	// Configuration word; reserved bits 5:3 never store
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			channel_config <= `CCFG_RST_CONFIG;
		else if (reg_wr && is_addr(reg_addr, `CCFG_ADDR_CONFIG))
			channel_config <= reg_wdata & `CCFG_MASK_CONFIG; // see [RULE1] see [RULE2] see [RULE3]
	end

	// Offset calibration pair
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			channel_offset_hi <= `CCFG_RST_OFFSET_HI;
			channel_offset_lo <= `CCFG_RST_OFFSET_LO;
		end
		else
		begin
			if (reg_wr && is_addr(reg_addr, `CCFG_ADDR_OFFSET_HI))
				channel_offset_hi <= reg_wdata; // see [RULE4]
			if (reg_wr && is_addr(reg_addr, `CCFG_ADDR_OFFSET_LO))
				channel_offset_lo <= reg_wdata & `CCFG_MASK_LO; // see [RULE5]
		end
	end

	// Gain calibration pair; mid-range gain out of reset
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			channel_gain_hi <= `CCFG_RST_GAIN_HI; // see [RULE7]
			channel_gain_lo <= `CCFG_RST_GAIN_LO; // see [RULE7]
		end
		else
		begin
			if (reg_wr && is_addr(reg_addr, `CCFG_ADDR_GAIN_HI))
				channel_gain_hi <= reg_wdata; // see [RULE6]
			if (reg_wr && is_addr(reg_addr, `CCFG_ADDR_GAIN_LO))
				channel_gain_lo <= reg_wdata & `CCFG_MASK_LO; // see [RULE8]
		end
	end

	// Tail word stores what the host writes; host keeps it zero
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			reserved_tail_word <= `CCFG_RST_TAIL;
		else if (reg_wr && is_addr(reg_addr, `CCFG_ADDR_TAIL))
			reserved_tail_word <= reg_wdata; // see [RULE10]
	end

	// Any accepted write to a stored word restarts the checksum
	assign ck_restart = reg_wr && (is_addr(reg_addr, `CCFG_ADDR_CONFIG)
		|| is_addr(reg_addr, `CCFG_ADDR_OFFSET_HI) || is_addr(reg_addr, `CCFG_ADDR_OFFSET_LO)
		|| is_addr(reg_addr, `CCFG_ADDR_GAIN_HI) || is_addr(reg_addr, `CCFG_ADDR_GAIN_LO)
		|| is_addr(reg_addr, `CCFG_ADDR_TAIL));

	// Serial checksum walk: one word per cycle keeps the logic small
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			ck_state              <= CCFG_CK_IDLE;
			ck_index              <= 3'h0;
			ck_acc                <= `CCFG_CRC_SEED;
			register_map_checksum <= `CCFG_RST_CHECKSUM;
		end
		else if (ck_restart)
		begin
			// A write mid-walk restarts so no stale word is folded in
			ck_state <= CCFG_CK_RUN; // see [RULE11]
			ck_index <= 3'h0;
			ck_acc   <= `CCFG_CRC_SEED;
		end
		else
		begin
			case (ck_state)
				CCFG_CK_IDLE:
				begin
					ck_state <= CCFG_CK_IDLE;
				end
				CCFG_CK_RUN:
				begin
					case (ck_index)
						3'h0: ck_acc <= crc_word(ck_acc, channel_config);
						3'h1: ck_acc <= crc_word(ck_acc, channel_offset_hi);
						3'h2: ck_acc <= crc_word(ck_acc, channel_offset_lo);
						3'h3: ck_acc <= crc_word(ck_acc, channel_gain_hi);
						3'h4: ck_acc <= crc_word(ck_acc, channel_gain_lo);
						default: ck_acc <= crc_word(ck_acc, reserved_tail_word);
					endcase
					if (ck_index == 3'h5)
						ck_state <= CCFG_CK_DONE;
					ck_index <= ck_index + 3'h1;
				end
				CCFG_CK_DONE:
				begin
					register_map_checksum <= ck_acc; // see [RULE9] see [RULE11]
					ck_state              <= CCFG_CK_IDLE;
				end
				default:
				begin
					ck_state <= CCFG_CK_IDLE;
				end
			endcase
		end
	end

	// Read path, one cycle latency; unmapped reads as zero
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_rd;
			if (!reg_rd)
				reg_rdata <= reg_rdata;
			else if (is_addr(reg_addr, `CCFG_ADDR_CONFIG))
				reg_rdata <= channel_config;
			else if (is_addr(reg_addr, `CCFG_ADDR_OFFSET_HI))
				reg_rdata <= channel_offset_hi;
			else if (is_addr(reg_addr, `CCFG_ADDR_OFFSET_LO))
				reg_rdata <= channel_offset_lo;
			else if (is_addr(reg_addr, `CCFG_ADDR_GAIN_HI))
				reg_rdata <= channel_gain_hi;
			else if (is_addr(reg_addr, `CCFG_ADDR_GAIN_LO))
				reg_rdata <= channel_gain_lo;
			else if (is_addr(reg_addr, `CCFG_ADDR_CHECKSUM))
				reg_rdata <= register_map_checksum; // see [RULE9]
			else if (is_addr(reg_addr, `CCFG_ADDR_TAIL))
				reg_rdata <= reserved_tail_word;
			else
				reg_rdata <= 16'h0000;
		end
	end

	// Field outputs to the datapath
	assign channel_phase_delay     = channel_config[`CCFG_PHASE_MSB:`CCFG_PHASE_LSB]; // see [RULE1]
	assign channel_dc_block_off    = channel_config[`CCFG_DCOFF_BIT];
	assign channel_dc_block_en     = !channel_config[`CCFG_DCOFF_BIT]; // see [RULE2]
	assign channel_dc_block_corner = channel_config[`CCFG_DCOFF_BIT] ? 4'h0 : global_dc_block_corner; // see [RULE2]
	assign channel_input_select    = ccfg_input_t'(channel_config[`CCFG_MUX_MSB:`CCFG_MUX_LSB]); // see [RULE3]
	assign channel_offset          = {channel_offset_hi, channel_offset_lo[`CCFG_LOBYTE_MSB:`CCFG_LOBYTE_LSB]};
	assign channel_gain            = {channel_gain_hi, channel_gain_lo[`CCFG_LOBYTE_MSB:`CCFG_LOBYTE_LSB]};
	assign checksum_busy           = (ck_state != CCFG_CK_IDLE);

	// Reserved config bits never hold a one
	a_cfg_reserved_zero: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RULE1]
		channel_config[5:3] == 3'h0) else $error("config reserved bits set");

	// Phase field follows a config write
	a_phase_write: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RULE1]
		reg_wr && reg_addr == `CCFG_ADDR_CONFIG |=> channel_phase_delay == $past(reg_wdata[15:6]))
		else $error("phase delay not stored");

	// Bypass forces zero corner
	a_dc_bypass: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RULE2]
		channel_dc_block_off |-> (!channel_dc_block_en && channel_dc_block_corner == 4'h0))
		else $error("dc block not bypassed");

	// Normal path follows global corner
	a_dc_global: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RULE2]
		!channel_dc_block_off |-> channel_dc_block_corner == global_dc_block_corner)
		else $error("dc corner not global");

	// Input select follows the low config bits
	a_mux_write: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RULE3]
		reg_wr && reg_addr == `CCFG_ADDR_CONFIG |=> channel_input_select == ccfg_input_t'($past(reg_wdata[1:0])))
		else $error("input select not stored");

	// Offset high word stored whole
	a_offset_hi: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RULE4]
		reg_wr && reg_addr == `CCFG_ADDR_OFFSET_HI |=> channel_offset[23:8] == $past(reg_wdata))
		else $error("offset high not stored");

	// Offset low byte comes from the upper half of its write
	a_offset_lo_store: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RULE5]
		reg_wr && reg_addr == `CCFG_ADDR_OFFSET_LO |=> channel_offset[7:0] == $past(reg_wdata[15:8]))
		else $error("offset low not stored");

	// Low words keep their low byte zero
	a_lo_bytes: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RULE5] see [RULE8]
		channel_offset_lo[7:0] == 8'h00 && channel_gain_lo[7:0] == 8'h00)
		else $error("reserved low byte set");

	// Gain high word stored whole
	a_gain_hi: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RULE6]
		reg_wr && reg_addr == `CCFG_ADDR_GAIN_HI |=> channel_gain[23:8] == $past(reg_wdata))
		else $error("gain high not stored");

	// Gain low byte comes from the upper half of its write
	a_gain_lo_store: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RULE8]
		reg_wr && reg_addr == `CCFG_ADDR_GAIN_LO |=> channel_gain[7:0] == $past(reg_wdata[15:8]))
		else $error("gain low not stored");

	// Gain comes out of reset at mid-range
	a_gain_reset: assert property (@(posedge clk_sys) // see [RULE7]
		!resetn |=> channel_gain == 24'h800000) else $error("gain reset wrong");

	// Checksum cannot be written by the host
	a_ck_readonly: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RULE9]
		reg_wr && reg_addr == `CCFG_ADDR_CHECKSUM && !checksum_busy |=> $stable(register_map_checksum))
		else $error("checksum written");

	// Checksum clears in reset; stale sums must not survive it
	a_ck_reset_zero: assert property (@(posedge clk_sys) // see [RULE9]
		!resetn |=> register_map_checksum == 16'h0000) else $error("checksum reset wrong");

	// A checksum read returns the sum held at the read edge
	a_ck_read: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RULE9]
		reg_rd && reg_addr == `CCFG_ADDR_CHECKSUM |=> reg_rvalid && reg_rdata == $past(register_map_checksum))
		else $error("checksum read wrong");

	// Checksum walk ends within eight cycles of a write
	a_ck_refresh: assert property (@(posedge clk_sys) disable iff (!resetn) // see [RULE11]
		ck_restart ##1 !ck_restart [*8] |-> !checksum_busy)
		else $error("checksum not refreshed");

endmodule // ccfg_regs

// File: ccfg_defs.svh
`ifndef CCFG_DEFS_SVH
`define CCFG_DEFS_SVH

// Register word addresses
`define CCFG_ADDR_CONFIG      6'h2c
`define CCFG_ADDR_OFFSET_HI   6'h2d
`define CCFG_ADDR_OFFSET_LO   6'h2e
`define CCFG_ADDR_GAIN_HI     6'h2f
`define CCFG_ADDR_GAIN_LO     6'h30
`define CCFG_ADDR_CHECKSUM    6'h3e
`define CCFG_ADDR_TAIL        6'h3f

// Reset values
`define CCFG_RST_CONFIG       16'h0000
`define CCFG_RST_OFFSET_HI    16'h0000
`define CCFG_RST_OFFSET_LO    16'h0000
`define CCFG_RST_GAIN_HI      16'h8000
`define CCFG_RST_GAIN_LO      16'h0000
`define CCFG_RST_CHECKSUM     16'h0000
`define CCFG_RST_TAIL         16'h0000

// Field positions
`define CCFG_PHASE_MSB        15
`define CCFG_PHASE_LSB        6
`define CCFG_DCOFF_BIT        2
`define CCFG_MUX_MSB          1
`define CCFG_MUX_LSB          0
`define CCFG_LOBYTE_MSB       15
`define CCFG_LOBYTE_LSB       8

// Writable bit masks
`define CCFG_MASK_CONFIG      16'hffc7
`define CCFG_MASK_LO          16'hff00

// Checksum polynomial (CCITT form)
`define CCFG_CRC_POLY         16'h1021
`define CCFG_CRC_SEED         16'hffff

`endif

// File: ccfg_pkg.sv
package ccfg_pkg;

	// Channel input selection codes
	typedef enum logic [1:0]
	{
		CCFG_IN_NORMAL  = 2'h0,
		CCFG_IN_SHORTED = 2'h1,
		CCFG_IN_POS_DC  = 2'h2,
		CCFG_IN_NEG_DC  = 2'h3
	} ccfg_input_t;

	// Checksum engine states
	typedef enum logic [2:0]
	{
		CCFG_CK_IDLE = 3'h1,
		CCFG_CK_RUN  = 3'h2,
		CCFG_CK_DONE = 3'h4
	} ccfg_ck_state_t;

endpackage

// File: ccfg_host.sv
`timescale 1ns/1ps
`include "ccfg_defs.svh"

module ccfg_host
(
	// Clock
	input  wire logic        clk_sys,
	// Register port towards the device
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [5:0]       reg_addr,
	output logic [15:0]      reg_wdata,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid
);
	// Quiet bus at time zero
	initial
	begin
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 6'h00;
		reg_wdata = 16'h0000;
	end

	// One write strobe; data inverted afterwards so stale data never looks valid
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= (a == `CCFG_ADDR_TAIL) ? 16'h0000 : d;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask

	// One read strobe; answer taken once the read edge has settled
	task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic v);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		#1;
		v = reg_rvalid;
		d = reg_rdata;
	endtask
endmodule // ccfg_host

// File: ccfg_regs_tb_top.sv
`timescale 1ns/1ps
`include "ccfg_defs.svh"

module ccfg_regs_tb_top
	import ccfg_pkg::*;
;
	logic               clk_sys;
	logic               resetn;
	logic               reg_wr;
	logic               reg_rd;
	logic [5:0]         reg_addr;
	logic [15:0]        reg_wdata;
	logic [15:0]        reg_rdata;
	logic               reg_rvalid;
	logic signed [9:0]  channel_phase_delay;
	logic               channel_dc_block_off;
	logic               channel_dc_block_en;
	logic [3:0]         global_dc_block_corner;
	logic [3:0]         channel_dc_block_corner;
	ccfg_input_t        channel_input_select;
	logic [23:0]        channel_offset;
	logic [23:0]        channel_gain;
	logic               checksum_busy;
	int                 fail_count;
	int                 total_checks;
	logic [15:0]        map_v[6];

	ccfg_regs u_ccfg_regs (.clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.channel_phase_delay(channel_phase_delay), .channel_dc_block_off(channel_dc_block_off),
		.channel_dc_block_en(channel_dc_block_en), .global_dc_block_corner(global_dc_block_corner),
		.channel_dc_block_corner(channel_dc_block_corner), .channel_input_select(channel_input_select),
		.channel_offset(channel_offset), .channel_gain(channel_gain), .checksum_busy(checksum_busy));
	ccfg_host u_ccfg_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	// Clock at 100 ns period
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	// Read one word and judge both the answer strobe and the data
	task automatic rchk(input logic [5:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic        v;
		u_ccfg_host.rd(a, d, v);
		chk("rvalid", 24'h1, {23'h0, v});
		chk("rdata", {8'h0, e}, {8'h0, d});
	endtask

	// Bench-side checksum, MSB first; computed over the expected words held in map_v, in order
	function automatic logic [15:0] crc_ref();
		logic [15:0] c;
		c = 16'hffff;
		for (int i = 0; i < 6; i++)
			for (int b = 15; b >= 0; b--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ map_v[i][b]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction

	task automatic t_reset();
		#1;
		chk("gain", 24'h800000, channel_gain);
		chk("offset", 24'h000000, channel_offset);
		rchk(`CCFG_ADDR_GAIN_HI, 16'h8000);
		rchk(`CCFG_ADDR_GAIN_LO, 16'h0000);
		rchk(`CCFG_ADDR_CHECKSUM, 16'h0000);
		rchk(`CCFG_ADDR_TAIL, 16'h0000);
		rchk(`CCFG_ADDR_CONFIG, 16'h0000);
		$display("test reset done");
	endtask

	// Every input code, both DC-block settings, negative phase near the limit
	task automatic t_config();
		logic [15:0] w;
		for (int m = 0; m < 4; m++)
		begin
			w = {10'h200 + 10'(m), 3'h7, m[0], m[1:0]};
			u_ccfg_host.wr(`CCFG_ADDR_CONFIG, w);
			#1;
			chk("phase", {14'h0, 10'h200 + 10'(m)}, {14'h0, channel_phase_delay});
			chk("select", 24'(m), {22'h0, channel_input_select});
			chk("dc_off", 24'(m % 2), {23'h0, channel_dc_block_off});
			chk("dc_en", 24'(1 - m % 2), {23'h0, channel_dc_block_en});
			chk("corner", (m % 2) ? 24'h0 : 24'ha, {20'h0, channel_dc_block_corner});
			rchk(`CCFG_ADDR_CONFIG, w & 16'hffc7);
			map_v[0] = w & 16'hffc7;
		end
		$display("test config done");
	endtask

	task automatic t_calib();
		u_ccfg_host.wr(`CCFG_ADDR_OFFSET_HI, 16'hffff);
		u_ccfg_host.wr(`CCFG_ADDR_OFFSET_LO, 16'h12ff);
		u_ccfg_host.wr(`CCFG_ADDR_GAIN_HI, 16'hfedc);
		u_ccfg_host.wr(`CCFG_ADDR_GAIN_LO, 16'habcd);
		#1;
		chk("offset", 24'hffff12, channel_offset);
		chk("gain", 24'hfedcab, channel_gain);
		rchk(`CCFG_ADDR_OFFSET_HI, 16'hffff);
		rchk(`CCFG_ADDR_OFFSET_LO, 16'h1200);
		rchk(`CCFG_ADDR_GAIN_HI, 16'hfedc);
		rchk(`CCFG_ADDR_GAIN_LO, 16'hab00);
		map_v[1] = 16'hffff;
		map_v[2] = 16'h1200;
		map_v[3] = 16'hfedc;
		map_v[4] = 16'hab00;
		$display("test calibration done");
	endtask

	// Walk starts on a stored write; checksum write tried once the walk is idle, and refused
	task automatic t_checksum();
		int n;
		u_ccfg_host.wr(`CCFG_ADDR_TAIL, 16'h0000);
		map_v[5] = 16'h0000;
		#1;
		chk("checksum_busy", 24'h1, {23'h0, checksum_busy});
		n = 0;
		while (checksum_busy !== 1'b0 && n < 40)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n == 40)
		begin
			chk("checksum_busy", 24'h0, {23'h0, checksum_busy});
			complete_run();
		end
		u_ccfg_host.wr(`CCFG_ADDR_CHECKSUM, 16'h5555);
		rchk(`CCFG_ADDR_CHECKSUM, crc_ref());
		rchk(6'h31, 16'h0000);
		$display("test checksum done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Reset for twelve cycles, then the scenarios
	initial
	begin
		fail_count = 0;
		total_checks = 0;
		map_v = '{default: 16'h0000};
		resetn = 1'b0;
		global_dc_block_corner = 4'ha;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_config();
		t_calib();
		t_checksum();
		complete_run();
	end
endmodule // ccfg_regs_tb_top
